// ===== dcf_ctrl.sv
// Purpose: dac load strobe, clear state, fault output and output-config control
// Assumes: pins sampled into aclk by three flops, axi4-lite register slave
// Notes:   "asynchronous" strobes are honoured within the synchroniser latency
// How it works
// - trim code 0 gives -25 percent, 1023 gives +25 percent, linearly.
// - low load strobe copies input register into dac register.
// - while load strobe stays low, input writes pass straight to dac register.
// - clear source one: clear input forces code from clear register.
// - clear source zero: clear input forces the zero output state.
// - clear pin disable one ignores the clear input.
// - clear input low with pin enabled enters clear state, flag reads one.
// - stay-in-clear: exit after clear high plus dac write, load, or strobe.
// - stay-in-clear: exit when clear high and software clears stay bit.
// - reset zeroes stay bit and releases clear state.
// - stay bit zero: exit on clear high, pin disable, or reset.
// - fault pin low when fault enable and any output fault flag.
// - fault pin low when clear-flag enable and clear state; else high.
// - voltage short flag follows short detection.
// - current open flag follows open or dropout detection.
// - config pins override software output bits unless both are high; range pin does unless both are high and range enable is set.
// - supply loss resets outputs to zero and all register bits to zero.
// - current zero state is 0 or 4 mA per range pin.
// - control bits d9..d2 as listed, all reset to zero.
// - config pins: 00 off, a current, b voltage, both software.
// - commands write input, write dac, or load input into dac.
`timescale 1ns/1ps
module dcf_ctrl #(
	parameter int CODE_W = 16
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  clk_en,
	// axi4-lite slave
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// device pins
	input  wire logic                  load_strobe_n,
	input  wire logic                  clear_in_n,
	input  wire logic                  output_config_pin_a,
	input  wire logic                  output_config_pin_b,
	input  wire logic                  current_range_pin,
	input  wire logic                  vout_short_det,
	input  wire logic                  iout_open_det,
	output logic                       fault_n_o,
	output logic                       fault_n_oe,
	// analog side
	output dcf_pkg::dcf_out_s          dac_out,
	output logic [10:0]                trim_gain
);

	// three-flop synchronisers for every pin; stage 1 feeds stage 2 only
	// presets match the idle pins (strobe and clear high, detectors low) so reset makes no false event
	logic [6:0] pin_raw, sync1_reg, sync2_reg, sync3_reg, pin_reg;
	assign pin_raw = {output_config_pin_b, output_config_pin_a, iout_open_det, vout_short_det,
		load_strobe_n, clear_in_n, current_range_pin};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= 7'h06;
			sync2_reg <= 7'h06;
			sync3_reg <= 7'h06;
			pin_reg   <= 7'h06;
		end else if (clk_en) begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			// a change counts once stages two and three agree
			for (int i = 0; i < 7; i++) begin
				if (sync2_reg[i] == sync3_reg[i]) begin
					pin_reg[i] <= sync3_reg[i];
				end
			end
		end
	end

	logic range_pin_s, clear_n_s, load_n_s, vshort_s, iopen_s;
	assign range_pin_s = pin_reg[0];
	assign clear_n_s   = pin_reg[1];
	assign load_n_s    = pin_reg[2];
	assign vshort_s    = pin_reg[3];
	assign iopen_s     = pin_reg[4];
	// config straps share the same filter, pin b above pin a
	logic [1:0] cnf_reg;
	assign cnf_reg     = pin_reg[6:5];

	// registers
	logic [15:0]       ctrl_reg;
	logic [CODE_W-1:0] input_reg;
	logic [CODE_W-1:0] dac_reg;
	logic [CODE_W-1:0] clrval_reg;
	logic [15:0]       trim_reg;
	dcf_pkg::dcf_state_e state_reg;

	// axi write channel: address and data taken in either order
	logic        aw_held_reg, w_held_reg;
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        wr_fire;
	logic        wr_hit;
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg  <= 1'b0;
			w_held_reg   <= 1'b0;
			awaddr_reg   <= 8'h00;
			wdata_reg    <= 32'h0000_0000;
			wstrb_reg    <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= dcf_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? dcf_pkg::RESP_OKAY : dcf_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// write decode
	logic wr_ctrl, wr_input, wr_dac, wr_load, wr_clrval, wr_trim;
	logic [15:0] wmask;
	assign wmask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	always_comb begin
		wr_ctrl = 1'b0;
		wr_input = 1'b0;
		wr_dac = 1'b0;
		wr_load = 1'b0;
		wr_clrval = 1'b0;
		wr_trim = 1'b0;
		wr_hit = 1'b1;
		if (awaddr_reg == dcf_pkg::CTRL_OFF) begin
			wr_ctrl = wr_fire;
		end else if (awaddr_reg == dcf_pkg::INPUT_OFF) begin
			wr_input = wr_fire;
		end else if (awaddr_reg == dcf_pkg::DACREG_OFF) begin
			wr_dac = wr_fire;
		end else if (awaddr_reg == dcf_pkg::LOADCMD_OFF) begin
			wr_load = wr_fire;
		end else if (awaddr_reg == dcf_pkg::CLRVAL_OFF) begin
			wr_clrval = wr_fire;
		end else if (awaddr_reg == dcf_pkg::TRIM_OFF) begin
			wr_trim = wr_fire;
		end else begin
			wr_hit = 1'b0;
		end
	end

	// register reset: supply loss is modelled by aresetn, all bits zero
	// control bits: only writable fields stored, flags live elsewhere
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= dcf_pkg::CTRL_RESET;
		end else if (clk_en && wr_ctrl) begin
			ctrl_reg <= (ctrl_reg & ~(wmask & dcf_pkg::CTRL_WMASK))
				| (wdata_reg[15:0] & wmask & dcf_pkg::CTRL_WMASK);
		end
	end

	// input, clear value and trim writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			input_reg  <= CODE_W'(dcf_pkg::CODE_RESET);
			clrval_reg <= CODE_W'(dcf_pkg::CODE_RESET);
			trim_reg   <= 16'h0000;
		end else if (clk_en) begin
			if (wr_input) begin
				input_reg <= wdata_reg[CODE_W-1:0];
			end
			if (wr_clrval) begin
				clrval_reg <= wdata_reg[CODE_W-1:0];
			end
			if (wr_trim) begin
				trim_reg <= wdata_reg[15:0];
			end
		end
	end

	// dac register: direct write, load command, or low strobe level, with input writes passed straight through while low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dac_reg <= CODE_W'(dcf_pkg::CODE_RESET);
		end else if (clk_en) begin
			if (wr_dac) begin
				dac_reg <= wdata_reg[CODE_W-1:0];
			end else if (!load_n_s && wr_input) begin
				dac_reg <= wdata_reg[CODE_W-1:0];
			end else if (!load_n_s || wr_load) begin
				dac_reg <= input_reg;
			end
		end
	end

	// clear state machine
	logic clear_req;
	logic stay_bit;
	logic stay_clearing;
	logic exit_event;
	// pin disable gates the clear input
	assign clear_req     = !ctrl_reg[dcf_pkg::CLR_DIS_BIT] && !clear_n_s;
	assign stay_bit      = ctrl_reg[dcf_pkg::STAY_BIT];
	assign stay_clearing = wr_ctrl && wstrb_reg[0] && !wdata_reg[dcf_pkg::STAY_BIT];
	// exit events once clear input is back high; the low strobe level covers its edge
	assign exit_event    = wr_dac || wr_load || !load_n_s;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= dcf_pkg::ST_RUN;
		end else if (clk_en) begin
			case (state_reg)
				dcf_pkg::ST_RUN: begin
					if (clear_req) begin
						state_reg <= dcf_pkg::ST_CLEAR;
					end
				end
				dcf_pkg::ST_CLEAR: begin
					if (clear_req) begin
						state_reg <= dcf_pkg::ST_CLEAR;
					end else if (!stay_bit) begin
						state_reg <= dcf_pkg::ST_RUN;
					end else if (clear_n_s && (stay_clearing || exit_event)) begin
						state_reg <= dcf_pkg::ST_RUN;
					end
				end
				default: begin
					state_reg <= dcf_pkg::ST_RUN;
				end
			endcase
		end
	end

	logic in_clear;
	assign in_clear = (state_reg == dcf_pkg::ST_CLEAR);

	// fault flags: live copies of the detector inputs
	logic vshort_flag, iopen_flag;
	assign vshort_flag = vshort_s;
	assign iopen_flag = iopen_s;

	// fault pin, open drain: drive low only
	logic fault_assert_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_assert_reg <= 1'b0;
		end else if (clk_en) begin
			fault_assert_reg <= (ctrl_reg[dcf_pkg::FAULT_EN_BIT] && (vshort_flag || iopen_flag))
				|| (ctrl_reg[dcf_pkg::CLRFLAG_EN_BIT] && in_clear);
		end
	end
	assign fault_n_o  = 1'b0;
	assign fault_n_oe = fault_assert_reg;

	// output selection and drive
	logic vout_sel, iout_sel, range_sel;
	always_comb begin
		case (cnf_reg)
			2'b01: begin
				vout_sel = 1'b0;
				iout_sel = 1'b1;
			end
			2'b10: begin
				vout_sel = 1'b1;
				iout_sel = 1'b0;
			end
			2'b11: begin
				vout_sel = ctrl_reg[dcf_pkg::VOUT_ON_BIT] && !ctrl_reg[dcf_pkg::IOUT_ON_BIT];
				iout_sel = ctrl_reg[dcf_pkg::IOUT_ON_BIT] && !ctrl_reg[dcf_pkg::VOUT_ON_BIT];
			end
			default: begin
				vout_sel = 1'b0;
				iout_sel = 1'b0;
			end
		endcase
		// range pin sets the 0/4 ma zero level; with both config pins high and range enable set, the software range bit does
		if (cnf_reg == 2'b11 && ctrl_reg[dcf_pkg::RANGE_SW_EN_BIT]) begin
			range_sel = ctrl_reg[dcf_pkg::RANGE_SW_BIT];
		end else begin
			range_sel = range_pin_s;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dac_out <= '0;
		end else if (clk_en) begin
			dac_out.vout_en    <= vout_sel;
			dac_out.iout_en    <= iout_sel;
			dac_out.range_4_20 <= range_sel;
			// zero state when source is zero
			dac_out.zero_state <= in_clear && !ctrl_reg[dcf_pkg::CLR_SRC_BIT];
			if (in_clear && ctrl_reg[dcf_pkg::CLR_SRC_BIT]) begin
				dac_out.code <= 16'(clrval_reg);
			end else if (in_clear) begin
				dac_out.code <= 16'h0000;
			end else begin
				dac_out.code <= 16'(dac_reg);
			end
		end
	end

	// trim gain: bits 8..0 are stored inverted, so the numeric value is {b9, ~b8..b0}
	// gain = 2*n - 1023, zero falls between n = 511 and 512; off while bit 15 is clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trim_gain <= 11'h000;
		end else if (clk_en) begin
			trim_gain <= trim_reg[15] ? 11'({trim_reg[9], ~trim_reg[8:0], 1'b0} - 11'(dcf_pkg::TRIM_MAX)) : 11'h000;
		end
	end

	// read channel
	logic [15:0] ctrl_view;
	always_comb begin
		ctrl_view = ctrl_reg;
		ctrl_view[dcf_pkg::VSHORT_BIT] = vshort_flag;
		ctrl_view[dcf_pkg::IOPEN_BIT]  = iopen_flag;
		ctrl_view[dcf_pkg::CLRST_BIT]  = in_clear;
	end

	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= dcf_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= dcf_pkg::RESP_OKAY;
				if (s_axi_araddr == dcf_pkg::CTRL_OFF) begin
					s_axi_rdata <= {16'h0000, ctrl_view};
				end else if (s_axi_araddr == dcf_pkg::INPUT_OFF) begin
					s_axi_rdata <= 32'(input_reg);
				end else if (s_axi_araddr == dcf_pkg::DACREG_OFF) begin
					s_axi_rdata <= 32'(dac_reg);
				end else if (s_axi_araddr == dcf_pkg::CLRVAL_OFF) begin
					s_axi_rdata <= 32'(clrval_reg);
				end else if (s_axi_araddr == dcf_pkg::STATUS_OFF) begin
					s_axi_rdata <= {26'h0, fault_assert_reg, vout_sel, iout_sel, range_sel, in_clear, !load_n_s};
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= dcf_pkg::RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// ===== dcf_ctrl_assertions.sv
// Purpose: port-level checker for the dac clear/fault/load control block
// Assumes: one clock, synchronous active-low reset, clk_en held high by the bench
// Notes:   pin filters take up to five edges, so pin relations wait eight samples
`timescale 1ns/1ps
module dcf_ctrl_assertions #(
	parameter int CODE_W = 16
) (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_arready,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              output_config_pin_a,
	input wire logic              output_config_pin_b,
	input wire logic              fault_n_o,
	input wire logic              fault_n_oe,
	input wire dcf_pkg::dcf_out_s dac_out
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// open drain: the data side never drives high
	property p_od_low; fault_n_o == 1'b0; endproperty
	a_od_low: assert property (p_od_low) else $error("fault data not low");
	property p_zero_code; dac_out.zero_state |-> dac_out.code == 16'h0000; endproperty
	a_zero_code: assert property (p_zero_code) else $error("zero state with code");
	property p_cfg_off;
		(!output_config_pin_a && !output_config_pin_b)[*8] |-> !dac_out.vout_en && !dac_out.iout_en;
	endproperty
	a_cfg_off: assert property (p_cfg_off) else $error("outputs on with pins low");
	property p_cfg_i;
		(output_config_pin_a && !output_config_pin_b)[*8] |-> dac_out.iout_en && !dac_out.vout_en;
	endproperty
	a_cfg_i: assert property (p_cfg_i) else $error("current output not chosen");
	property p_cfg_v;
		(!output_config_pin_a && output_config_pin_b)[*8] |-> dac_out.vout_en && !dac_out.iout_en;
	endproperty
	a_cfg_v: assert property (p_cfg_v) else $error("voltage output not chosen");
	// first edge out of reset still shows the cleared state
	property p_rst; $rose(aresetn) |-> dac_out == 20'h00000 && !fault_n_oe; endproperty
	a_rst: assert property (p_rst) else $error("outputs not zero after reset");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_ar_ref; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ar_ref: assert property (p_ar_ref) else $error("read taken while answer pending");
	property p_aw_ref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_aw_ref: assert property (p_aw_ref) else $error("write taken while answer pending");
	property p_b_after;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_b_after: assert property (p_b_after) else $error("write answer late");

	c_clear: cover property (dac_out.zero_state);
	c_fault: cover property (fault_n_oe);
	c_rwait: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

// ===== dcf_ctrl_tb.sv
// Purpose: self-checking bench for the dac clear/fault/load control block
// Assumes: clk_en and write strobes held on; pins driven through the host model
// Notes:   expected codes come from the register values the bench writes
`timescale 1ns/1ps
module dcf_ctrl_tb;
	localparam int STB = 6, CLR = 5, PA = 4, PB = 3, RNG = 2, VS = 1, IO = 0;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid, fault_n_o, fault_n_oe, fault_wire;
	logic [1:0] bresp, rresp;
	logic [6:0] pins;
	logic [10:0] trim_gain;
	dcf_pkg::dcf_out_s dac_out;
	int num_errors = 0, checks_done = 0;

	always #12.5 aclk = ~aclk;

	dcf_ctrl i_dcf_ctrl (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.load_strobe_n(pins[STB]), .clear_in_n(pins[CLR]), .output_config_pin_a(pins[PA]),
		.output_config_pin_b(pins[PB]), .current_range_pin(pins[RNG]), .vout_short_det(pins[VS]),
		.iout_open_det(pins[IO]), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe), .dac_out(dac_out),
		.trim_gain(trim_gain));
	dcf_pin_host i_dcf_pin_host (.aclk(aclk), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
		.pins(pins), .fault_wire(fault_wire));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// master offers address and data together, releases each when taken
	task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er = dcf_pkg::RESP_OKAY);
		logic ta, tw, tb;
		logic [1:0] r;
		tb = 0;
		r = 2'b11;
		@(posedge aclk);
		awaddr <= ad; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		for (int n = 0; n < 50 && !tb; n++) begin
			@(negedge aclk);
			ta = awvalid && awready; tw = wvalid && wready; tb = bvalid; r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 0;
			if (tw) wvalid <= 0;
			if (tb) bready <= 0;
		end
		@(negedge aclk);
		chk("bvalid", 32'h1, {31'h0, tb});
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask

	// rready comes late on purpose so the answer must stand
	task automatic rd(input logic [7:0] ad, input logic [1:0] er, input logic [31:0] ed);
		logic ta, td;
		logic [31:0] d;
		logic [1:0] r;
		td = 0;
		@(posedge aclk);
		araddr <= ad; arvalid <= 1;
		for (int n = 0; n < 50 && !td; n++) begin
			@(negedge aclk);
			ta = arvalid && arready; td = rvalid && rready; d = rdata; r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 0;
			if (n == 1) rready <= 1;
			if (td) rready <= 0;
		end
		@(negedge aclk);
		chk("rvalid", 32'h1, {31'h0, td});
		chk("rdata", ed, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask

	task automatic rst;
		@(posedge aclk);
		aresetn <= 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		@(negedge aclk);
	endtask

	task automatic print_verdict;
		if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic t_regs;
		rd(dcf_pkg::CTRL_OFF, dcf_pkg::RESP_OKAY, 32'h0);
		rd(8'h1c, dcf_pkg::RESP_SLVERR, 32'h0);
		wr(8'h1c, 32'h0, dcf_pkg::RESP_SLVERR);
		wr(dcf_pkg::CTRL_OFF, 32'h3fff);
		rd(dcf_pkg::CTRL_OFF, dcf_pkg::RESP_OKAY, 32'h3fe0);
		wr(dcf_pkg::CTRL_OFF, 32'h0);
	endtask

	task automatic t_load;
		wr(dcf_pkg::INPUT_OFF, 32'h1234);
		chk("code", 32'h0, dac_out.code);
		i_dcf_pin_host.put(STB, 0);
		chk("code", 32'h1234, dac_out.code);
		wr(dcf_pkg::INPUT_OFF, 32'h5678);
		chk("code", 32'h5678, dac_out.code);
		i_dcf_pin_host.put(STB, 1);
		wr(dcf_pkg::INPUT_OFF, 32'h1111);
		wr(dcf_pkg::LOADCMD_OFF, 32'h0);
		chk("code", 32'h1111, dac_out.code);
		wr(dcf_pkg::DACREG_OFF, 32'h2222);
		chk("code", 32'h2222, dac_out.code);
	endtask

	task automatic t_clear;
		wr(dcf_pkg::CLRVAL_OFF, 32'habcd);
		wr(dcf_pkg::CTRL_OFF, 32'h0120);
		i_dcf_pin_host.put(CLR, 0);
		chk("code", 32'habcd, dac_out.code);
		rd(dcf_pkg::CTRL_OFF, dcf_pkg::RESP_OKAY, 32'h0124);
		chk("fault", 32'h0, fault_wire);
		i_dcf_pin_host.put(CLR, 1);
		chk("code", 32'h2222, dac_out.code);
		chk("fault", 32'h1, fault_wire);
		wr(dcf_pkg::CTRL_OFF, 32'h0);
		i_dcf_pin_host.put(CLR, 0);
		chk("zero", 32'h1, dac_out.zero_state);
		wr(dcf_pkg::CTRL_OFF, 32'h0200);
		// the exit reaches the output two edges after the write lands
		@(negedge aclk);
		chk("code", 32'h2222, dac_out.code);
		i_dcf_pin_host.put(CLR, 1);
	endtask

	// stay-in-clear: dac write, strobe and stay-bit exits (not the load command), then reset
	task automatic t_stay;
		wr(dcf_pkg::CTRL_OFF, 32'h0180);
		i_dcf_pin_host.put(CLR, 0);
		i_dcf_pin_host.put(CLR, 1);
		chk("code", 32'habcd, dac_out.code);
		wr(dcf_pkg::DACREG_OFF, 32'h3333);
		chk("code", 32'h3333, dac_out.code);
		i_dcf_pin_host.put(CLR, 0);
		i_dcf_pin_host.put(CLR, 1);
		i_dcf_pin_host.put(STB, 0);
		i_dcf_pin_host.put(STB, 1);
		chk("code", 32'h1111, dac_out.code);
		i_dcf_pin_host.put(CLR, 0);
		i_dcf_pin_host.put(CLR, 1);
		wr(dcf_pkg::CTRL_OFF, 32'h0100);
		chk("code", 32'h1111, dac_out.code);
		wr(dcf_pkg::CTRL_OFF, 32'h0180);
		i_dcf_pin_host.put(CLR, 0);
		i_dcf_pin_host.put(CLR, 1);
		rst();
		chk("out", 32'h0, dac_out);
		rd(dcf_pkg::CTRL_OFF, dcf_pkg::RESP_OKAY, 32'h0);
	endtask

	task automatic t_fault;
		wr(dcf_pkg::CTRL_OFF, 32'h0040);
		i_dcf_pin_host.put(VS, 1);
		chk("fault", 32'h0, fault_wire);
		rd(dcf_pkg::CTRL_OFF, dcf_pkg::RESP_OKAY, 32'h0050);
		i_dcf_pin_host.put(VS, 0);
		i_dcf_pin_host.put(IO, 1);
		rd(dcf_pkg::CTRL_OFF, dcf_pkg::RESP_OKAY, 32'h0048);
		wr(dcf_pkg::CTRL_OFF, 32'h0);
		chk("fault", 32'h1, fault_wire);
		i_dcf_pin_host.put(IO, 0);
	endtask

	task automatic t_cfg;
		i_dcf_pin_host.put(PA, 1);
		chk("outs", 32'h1, {dac_out.vout_en, dac_out.iout_en});
		i_dcf_pin_host.put(RNG, 1);
		chk("range", 32'h1, dac_out.range_4_20);
		i_dcf_pin_host.put(PB, 1);
		wr(dcf_pkg::CTRL_OFF, 32'h1000);
		chk("outs", 32'h2, {dac_out.vout_en, dac_out.iout_en});
		i_dcf_pin_host.put(PA, 0);
		wr(dcf_pkg::CTRL_OFF, 32'h2000);
		chk("outs", 32'h2, {dac_out.vout_en, dac_out.iout_en});
		i_dcf_pin_host.put(PB, 0);
		chk("outs", 32'h0, {dac_out.vout_en, dac_out.iout_en});
	endtask

	task automatic t_trim;
		wr(dcf_pkg::TRIM_OFF, 32'h8200);
		chk("trim", 32'h3ff, trim_gain);
		wr(dcf_pkg::TRIM_OFF, 32'h81ff);
		chk("trim", 32'h401, trim_gain);
		wr(dcf_pkg::TRIM_OFF, 32'h8000);
		chk("trim", 32'h7ff, trim_gain);
		wr(dcf_pkg::TRIM_OFF, 32'h03ff);
		chk("trim", 32'h0, trim_gain);
	endtask

	initial begin
		rst();
		t_regs();
		t_load();
		t_clear();
		t_stay();
		t_fault();
		t_cfg();
		t_trim();
		print_verdict();
	end

	// watchdog: the whole run needs well under two thousand cycles
	initial begin
		repeat (6000) @(posedge aclk);
		num_errors++;
		print_verdict();
	end
endmodule

bind dcf_ctrl dcf_ctrl_assertions #(.CODE_W(CODE_W)) i_dcf_ctrl_assertions (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.output_config_pin_a(output_config_pin_a), .output_config_pin_b(output_config_pin_b),
	.fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe), .dac_out(dac_out));

// ===== dcf_pin_host.sv
// Purpose: host side of the device pins and the pulled-up fault wire
// Assumes: pins change just after a rising edge, detectors act as levels
// Notes:   put waits long enough for the pin filters and the output register
`timescale 1ns/1ps
module dcf_pin_host (
	input wire logic  aclk,
	input wire logic  fault_n_o,
	input wire logic  fault_n_oe,
	output logic [6:0] pins,
	output logic       fault_wire
);
	initial pins = 7'h60;
	assign fault_wire = fault_n_oe ? fault_n_o : 1'b1;

	task automatic put(input int i, input logic v);
		@(posedge aclk);
		pins[i] <= v;
		repeat (6) @(posedge aclk);
		@(negedge aclk);
	endtask
endmodule

// ===== dcf_pkg.sv
// Purpose: shared constants and types for the dac clear/fault/load control block
// Assumes: 32-bit axi4-lite register access, one clock
// Notes:   offsets are byte addresses of aligned words
package dcf_pkg;

	// register byte offsets
	localparam logic [7:0] CTRL_OFF    = 8'h00;
	localparam logic [7:0] INPUT_OFF   = 8'h04;
	localparam logic [7:0] DACREG_OFF  = 8'h08;
	localparam logic [7:0] LOADCMD_OFF = 8'h0c;
	localparam logic [7:0] CLRVAL_OFF  = 8'h10;
	localparam logic [7:0] TRIM_OFF    = 8'h14;
	localparam logic [7:0] STATUS_OFF  = 8'h18;

	// control register field positions
	localparam int CLR_DIS_BIT    = 9;
	localparam int CLR_SRC_BIT    = 8;
	localparam int STAY_BIT       = 7;
	localparam int FAULT_EN_BIT   = 6;
	localparam int CLRFLAG_EN_BIT = 5;
	localparam int VSHORT_BIT     = 4;
	localparam int IOPEN_BIT      = 3;
	localparam int CLRST_BIT      = 2;
	// software output-configuration bits, above the documented ones
	localparam int RANGE_SW_EN_BIT = 10;
	localparam int RANGE_SW_BIT    = 11;
	localparam int VOUT_ON_BIT     = 12;
	localparam int IOUT_ON_BIT     = 13;

	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CODE_RESET = 16'h0000;
	localparam logic [15:0] CTRL_WMASK = 16'h3fe0;

	// trim: numeric value zero is -25 percent, 1023 is +25 percent
	localparam int TRIM_MAX     = 1023;
	localparam int TRIM_PCT_MIN = -25;
	localparam int TRIM_PCT_MAX = 25;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// one-hot clear-state machine
	typedef enum logic [1:0] {
		ST_RUN   = 2'b01,
		ST_CLEAR = 2'b10
	} dcf_state_e;

	// what the analog side is told to do
	typedef struct packed {
		logic        vout_en;
		logic        iout_en;
		logic        range_4_20;
		logic        zero_state;
		logic [15:0] code;
	} dcf_out_s;

endpackage
